/* core/lldp_fifo.sv */
// Module: parameterised valid/ready FIFO for write beats
`timescale 1ns/1ns
module lldp_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  // Depth must be a power of two for pointer wrap
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage
  logic [PW:0] wr_q, wr_d, rd_q, rd_d; // Pointers with wrap bit
  logic push, pop;
  // ----------------------------------------------------------------
  // Next pointer values
  // ----------------------------------------------------------------
  always_comb begin
    in_ready_o = (wr_q - rd_q) != (PW+1)'(DEPTH); // Honest full
    out_valid_o = wr_q != rd_q; // Honest empty
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_d = wr_q + (PW+1)'(push);
    rd_d = rd_q + (PW+1)'(pop);
    out_data_o = mem_q[rd_q[PW-1:0]];
  end
  // Register pointers and storage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= in_data_i;
    end
  end
endmodule // lldp_fifo

/* core/lldp_pkg.sv */
// Package: constants for the low-latency DRAM command and data port
package lldp_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22; // Row and column address lines
  localparam int BANK_W = 3; // Bank select lines
  localparam int NUM_BANKS = 8; // Binary decode of the bank lines
  localparam int DATA_W = 36; // Widest data bus
  localparam int LANE_W = 18; // Lines per write clock in the wide build
  localparam int FIFO_DEPTH = 16; // Write beat buffer depth
  // ----------------------------------------------------------------
  // Command encoding, active low {cs_n, we_n, ref_n}
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0; // Mode register set
  localparam logic [2:0] CMD_WRITE = 3'h1; // Write
  localparam logic [2:0] CMD_REFRESH = 3'h2; // Refresh
  localparam logic [2:0] CMD_READ = 3'h3; // Read
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20; // System clock rate
  localparam int READ_BEATS = 2; // Beats driven per read command
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [21:0] MODE_RESET = 22'h00_0000; // Mode register after reset
endpackage

/* core/lldp_port.sv */
// Module: command, address and data capture port of the DRAM device
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Parameters and ports
// ----------------------------------------------------------------
module lldp_port #(
  parameter int DATA_W = lldp_pkg::DATA_W, // Data bus width: 9, 18 or 36
  parameter int WIDE = 1 // 1: two write clocks split the lanes
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command side pins, all asynchronous to clk_i
  input wire logic command_clock_i, // Link clock, sampled
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic ref_n_i,
  input wire logic [lldp_pkg::ADDR_W-1:0] row_col_address_lines_i,
  input wire logic [lldp_pkg::BANK_W-1:0] bank_select_lines_i,
  // Write data side pins
  input wire logic write_data_clock_lane0_i,
  input wire logic write_data_clock_lane1_i,
  input wire logic write_mask_i,
  input wire logic [DATA_W-1:0] bidir_data_lines_i,
  // Read data side
  output logic [DATA_W-1:0] bidir_data_lines_o,
  output logic bidir_data_lines_oe_o,
  output logic read_echo_clock_o,
  output logic read_valid_flag_o,
  // Decoded results for the core
  output logic [lldp_pkg::NUM_BANKS-1:0] bank_onehot_o, // Bank of last command
  output logic [lldp_pkg::ADDR_W-1:0] access_address_o, // Row/col of last access
  output logic [lldp_pkg::ADDR_W-1:0] mode_settings_o, // Mode register
  output logic refresh_pulse_o, // One cycle per refresh command
  // Write beat stream towards the core
  output logic [DATA_W+lldp_pkg::BANK_W:0] wr_beat_o, // {bank, lane0 hit, data}
  output logic wr_beat_valid_o,
  input wire logic wr_beat_ready_i,
  input wire logic [DATA_W-1:0] rd_data_i, // Core read data, same clock
  output logic fifo_ready_o // Low when write beats back up
);
  // ----------------------------------------------------------------
  // Elaboration checks: only the three bus widths are served
  // ----------------------------------------------------------------
  if (DATA_W != 9 && DATA_W != 18 && DATA_W != 36) begin : g_bad_width
    $error("DATA_W must be 9, 18 or 36");
  end
  // Two write clocks only make sense with two lane halves
  if (WIDE == 1 && DATA_W != 36) begin : g_bad_split
    $error("Split lanes need the 36-line build");
  end
  if (WIDE != 0 && WIDE != 1) begin : g_bad_wide
    $error("WIDE must be 0 or 1");
  end
  // Split point between the two lane halves
  localparam int HALF = DATA_W / 2;
  // ----------------------------------------------------------------
  // Synchronisers: every pin passes two flops
  // ----------------------------------------------------------------
  // One wide bus per stage keeps all pins aligned in time
  // Trade-off: a skewed pin may land a cycle late; frames are long
  logic [lldp_pkg::ADDR_W+lldp_pkg::BANK_W+DATA_W+6:0] s1_q, s2_q;
  logic ck_q, dk0_q, dk1_q; // Previous synchronised clock levels
  always_ff @(posedge clk_i) begin
    s1_q <= {command_clock_i, cs_n_i, we_n_i, ref_n_i, row_col_address_lines_i,
             bank_select_lines_i, write_data_clock_lane0_i, write_data_clock_lane1_i,
             write_mask_i, bidir_data_lines_i};
    s2_q <= s1_q;
  end
  logic ck_s, cs_s, we_s, ref_s, dk0_s, dk1_s, dm_s;
  logic [lldp_pkg::ADDR_W-1:0] a_s;
  logic [lldp_pkg::BANK_W-1:0] b_s;
  logic [DATA_W-1:0] dq_s;
  // Unpack the second stage; nothing reads the first stage
  assign {ck_s, cs_s, we_s, ref_s, a_s, b_s, dk0_s, dk1_s, dm_s, dq_s} = s2_q;
  // ----------------------------------------------------------------
  // Command decode state
  // ----------------------------------------------------------------
  // Read burst sequencer, one-hot
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_BURST = 2'b10} lldp_rd_type;
  lldp_rd_type rd_q, rd_d;
  logic ck_rise, wr_pending_q, wr_pending_d;
  logic [lldp_pkg::NUM_BANKS-1:0] bank_d;
  logic [lldp_pkg::ADDR_W-1:0] addr_d, mode_d;
  logic [lldp_pkg::BANK_W-1:0] wbank_q, wbank_d;
  logic [1:0] beat_q, beat_d;
  logic ref_d, qk_d;
  logic [DATA_W-1:0] dout_d;
  // Decode on the sampled rising command clock edge only
  always_comb begin
    ck_rise = ck_s && !ck_q;
    bank_d = bank_onehot_o;
    addr_d = access_address_o;
    mode_d = mode_settings_o;
    wbank_d = wbank_q;
    wr_pending_d = wr_pending_q;
    ref_d = 1'b0;
    rd_d = rd_q;
    beat_d = beat_q;
    qk_d = read_echo_clock_o;
    dout_d = bidir_data_lines_o;
    if (ck_rise && !cs_s) begin
      // Deselected cycles fall through; bursts below keep running
      bank_d = lldp_pkg::NUM_BANKS'(1) << b_s;
      unique case ({cs_s, we_s, ref_s})
        lldp_pkg::CMD_MRS: mode_d = a_s;
        lldp_pkg::CMD_WRITE: begin
          addr_d = a_s;
          wbank_d = b_s;
          wr_pending_d = 1'b1;
        end
        lldp_pkg::CMD_REFRESH: ref_d = 1'b1;
        lldp_pkg::CMD_READ: begin
          addr_d = a_s;
          rd_d = RD_BURST;
          beat_d = '0;
        end
        default: ;
      endcase
    end
    // Read burst: one beat per echo edge, two per echo cycle
    unique case (rd_q)
      RD_IDLE: qk_d = 1'b0;
      RD_BURST: begin
        qk_d = !read_echo_clock_o;
        dout_d = rd_data_i;
        beat_d = beat_q + 2'd1;
        if (beat_q == 2'(lldp_pkg::READ_BEATS - 1)) rd_d = RD_IDLE;
      end
    endcase
  end
  // Register decode state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ck_q <= 1'b0;
      bank_onehot_o <= '0;
      access_address_o <= '0;
      mode_settings_o <= lldp_pkg::MODE_RESET;
      wbank_q <= '0;
      wr_pending_q <= 1'b0;
      refresh_pulse_o <= 1'b0;
      rd_q <= RD_IDLE;
      beat_q <= '0;
      read_echo_clock_o <= 1'b0;
      bidir_data_lines_o <= '0;
      read_valid_flag_o <= 1'b0;
    end else begin
      ck_q <= ck_s;
      bank_onehot_o <= bank_d;
      access_address_o <= addr_d;
      mode_settings_o <= mode_d;
      wbank_q <= wbank_d;
      wr_pending_q <= wr_pending_d;
      refresh_pulse_o <= ref_d;
      rd_q <= rd_d;
      beat_q <= beat_d;
      read_echo_clock_o <= qk_d;
      bidir_data_lines_o <= dout_d;
      // Valid trails the sequencer by a cycle so it lines up with data
      read_valid_flag_o <= (rd_q == RD_BURST);
    end
  end
  // Drive the shared lines only while valid beats stand
  assign bidir_data_lines_oe_o = read_valid_flag_o;
  // ----------------------------------------------------------------
  // Write capture on both edges of each write data clock
  // ----------------------------------------------------------------
  logic dk0_edge, dk1_edge, beat_ok;
  logic [DATA_W-1:0] wdata;
  // An edge of either polarity is one beat; both halves share one push
  always_comb begin
    dk0_edge = dk0_s ^ dk0_q;
    dk1_edge = (WIDE == 1) ? (dk1_s ^ dk1_q) : dk0_edge;
    wdata = '0;
    if (WIDE == 1) begin
      if (dk0_edge) wdata[HALF-1:0] = dq_s[HALF-1:0];
      if (dk1_edge) wdata[DATA_W-1:HALF] = dq_s[DATA_W-1:HALF];
    end else if (dk0_edge) begin
      wdata = dq_s;
    end
    // Mask follows the upper-lane clock in the split build
    beat_ok = wr_pending_q && (WIDE == 1 ? dk1_edge : dk0_edge) && !dm_s;
  end
  // Track write clock levels
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dk0_q <= 1'b0;
      dk1_q <= 1'b0;
    end else begin
      dk0_q <= dk0_s;
      dk1_q <= dk1_s; // Lane 1 clock always sampled
    end
  end
  // Write beats wait here until the core takes them
  // Limitation: beats arriving while full are lost; the host must pace
  lldp_fifo #(.WIDTH(DATA_W + lldp_pkg::BANK_W + 1), .DEPTH(lldp_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i({wbank_q, dk0_edge, wdata}),
    .in_valid_i(beat_ok),
    .in_ready_o(fifo_ready_o),
    .out_data_o(wr_beat_o),
    .out_valid_o(wr_beat_valid_o),
    .out_ready_i(wr_beat_ready_i)
  );
endmodule // lldp_port

/* verification/lldp_host_model.sv */
// Host controller model driving commands and write beats into the port
`timescale 1ns/1ns
module lldp_host_model (
  input wire logic clk_i,
  output logic cmd_clk_o,
  output logic cs_n_o,
  output logic we_n_o,
  output logic ref_n_o,
  output logic [21:0] addr_o,
  output logic [2:0] bank_o,
  output logic dk0_o,
  output logic dk1_o,
  output logic mask_o,
  output logic [35:0] dq_o
);
  // ----------------------------------------------------------------
  // Idle levels: deselected, link clocks parked low
  // ----------------------------------------------------------------
  initial begin
    {cmd_clk_o, dk0_o, dk1_o, mask_o} = 4'h0;
    {cs_n_o, we_n_o, ref_n_o} = 3'h7;
    addr_o = 22'h15_5555;
    bank_o = 3'h5;
    dq_o = 36'h5_5555_5555;
  end
  // One command frame of eight cycles (400 ns at the 50 ns clock period)
  task automatic cmd(input logic [2:0] code, input logic [2:0] bank, input logic [21:0] addr);
    @(posedge clk_i);
    {cs_n_o, we_n_o, ref_n_o} <= code;
    bank_o <= bank;
    addr_o <= addr;
    cmd_clk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmd_clk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    {cs_n_o, we_n_o, ref_n_o} <= 3'h7;
    // Released lines show the inverse, not a stale copy
    bank_o <= ~bank;
    addr_o <= ~addr;
  endtask
  // One beat per write clock edge; both pairs always toggled
  task automatic beat(input logic [35:0] data, input logic mask);
    @(posedge clk_i);
    dq_o <= data;
    mask_o <= mask;
    dk0_o <= ~dk0_o;
    dk1_o <= ~dk1_o;
    repeat (3) @(posedge clk_i);
    dq_o <= ~data;
  endtask
endmodule // lldp_host_model

/* verification/lldp_port_checker.sv */
// Checker: concurrent assertions on the port's pins
`timescale 1ns/1ns
module lldp_port_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic command_clock_i,
  input wire logic cs_n_i,
  input wire logic read_valid_flag_o,
  input wire logic bidir_data_lines_oe_o,
  input wire logic read_echo_clock_o,
  input wire logic [7:0] bank_onehot_o,
  input wire logic [21:0] access_address_o,
  input wire logic [21:0] mode_settings_o,
  input wire logic refresh_pulse_o,
  input wire logic wr_beat_valid_o,
  input wire logic fifo_ready_o
);
  // ----------------------------------------------------------------
  // Assertions, all in the system clock domain
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  oe_tracks_valid_a: assert property (bidir_data_lines_oe_o == read_valid_flag_o)
    else $error("data enable differs from read valid");
  read_two_beats_a: assert property ($rose(read_valid_flag_o) |=> read_valid_flag_o ##1 !read_valid_flag_o)
    else $error("read burst not two cycles");
  echo_leads_valid_a: assert property ($rose(read_valid_flag_o) |-> $rose(read_echo_clock_o))
    else $error("valid without echo edge");
  echo_in_burst_a: assert property (read_echo_clock_o |-> ##[0:1] read_valid_flag_o)
    else $error("echo clock outside a burst");
  refresh_single_a: assert property (refresh_pulse_o |=> !refresh_pulse_o)
    else $error("refresh pulse too long");
  bank_onehot_a: assert property ($changed(bank_onehot_o) |-> $onehot(bank_onehot_o))
    else $error("bank select not one-hot");
  no_rise_quiet_a: assert property ((!command_clock_i)[*8] |->
    $stable(mode_settings_o) && $stable(access_address_o) && !refresh_pulse_o)
    else $error("command taken without clock rise");
  deselect_quiet_a: assert property (cs_n_i[*8] |->
    $stable(mode_settings_o) && $stable(bank_onehot_o) && !refresh_pulse_o)
    else $error("command taken while deselected");
  full_holds_out_a: assert property (!fifo_ready_o |-> wr_beat_valid_o)
    else $error("buffer full but nothing offered");
endmodule // lldp_port_checker
bind lldp_port lldp_port_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .command_clock_i(command_clock_i), .cs_n_i(cs_n_i), .read_valid_flag_o(read_valid_flag_o),
  .bidir_data_lines_oe_o(bidir_data_lines_oe_o), .read_echo_clock_o(read_echo_clock_o),
  .bank_onehot_o(bank_onehot_o), .access_address_o(access_address_o),
  .mode_settings_o(mode_settings_o), .refresh_pulse_o(refresh_pulse_o),
  .wr_beat_valid_o(wr_beat_valid_o), .fifo_ready_o(fifo_ready_o));

/* verification/lldp_port_tb.sv */
// Testbench: command table, deselect, reset and write buffer cases
`timescale 1ns/1ns
module lldp_port_tb;
  typedef struct {logic [2:0] code; logic [2:0] bank; logic [21:0] addr;
    logic [7:0] onehot; logic [21:0] acc; logic [21:0] mode; int nref; int nvld;} lldp_row_type;
  lldp_row_type rows [4];
  logic clk = 1'b0, rst_n = 1'b0, wr_rdy = 1'b0, cmd_clk, cs_n, we_n, ref_n, dk0, dk1, mask;
  logic oe, echo, vld, refp, bvld, f_rdy;
  logic [21:0] addr, acc, mode;
  logic [2:0] bank;
  logic [7:0] onehot;
  logic [35:0] host_dq, dq_o, dq_w, rd_seen;
  logic [39:0] beat, first;
  int errors = 0, n_compared = 0, nref = 0, nvld = 0, nbeat = 0, necho = 0;
  // ----------------------------------------------------------------
  // Clock, wire resolution and design
  // ----------------------------------------------------------------
  always #25 clk = ~clk;
  assign dq_w = oe ? dq_o : host_dq; // Device wins while it drives
  lldp_host_model host_u (.clk_i(clk), .cmd_clk_o(cmd_clk), .cs_n_o(cs_n), .we_n_o(we_n),
    .ref_n_o(ref_n), .addr_o(addr), .bank_o(bank), .dk0_o(dk0), .dk1_o(dk1), .mask_o(mask),
    .dq_o(host_dq));
  lldp_port dut_u (.clk_i(clk), .rst_n_i(rst_n), .command_clock_i(cmd_clk), .cs_n_i(cs_n),
    .we_n_i(we_n), .ref_n_i(ref_n), .row_col_address_lines_i(addr), .bank_select_lines_i(bank),
    .write_data_clock_lane0_i(dk0), .write_data_clock_lane1_i(dk1), .write_mask_i(mask),
    .bidir_data_lines_i(dq_w), .bidir_data_lines_o(dq_o), .bidir_data_lines_oe_o(oe),
    .read_echo_clock_o(echo), .read_valid_flag_o(vld), .bank_onehot_o(onehot),
    .access_address_o(acc), .mode_settings_o(mode), .refresh_pulse_o(refp), .wr_beat_o(beat),
    .wr_beat_valid_o(bvld), .wr_beat_ready_i(wr_rdy), .rd_data_i(36'h9_8765_4321),
    .fifo_ready_o(f_rdy));
  // Monitors: pulse counts, read data, drained beats
  always @(posedge clk) begin
    if (refp === 1'b1) nref <= nref + 1;
    if (vld === 1'b1) nvld <= nvld + 1;
    if (vld === 1'b1) rd_seen <= dq_o;
    if (echo === 1'b1) necho <= necho + 1;
    if (bvld === 1'b1 && wr_rdy) nbeat <= nbeat + 1;
    if (bvld === 1'b1 && wr_rdy && nbeat == 0) first <= beat;
  end
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(1500 * 50);
    errors++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{3'h0, 3'h0, 22'h2a_5a5a, 8'h01, 22'h00_0000, 22'h2a_5a5a, 0, 0};
    rows[1] = '{3'h1, 3'h3, 22'h15_0f0f, 8'h08, 22'h15_0f0f, 22'h2a_5a5a, 0, 0};
    rows[2] = '{3'h2, 3'h6, 22'h00_1234, 8'h40, 22'h15_0f0f, 22'h2a_5a5a, 1, 0};
    rows[3] = '{3'h3, 3'h7, 22'h3f_ffff, 8'h80, 22'h3f_ffff, 22'h2a_5a5a, 1, 2};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      host_u.cmd(rows[i].code, rows[i].bank, rows[i].addr);
      repeat (6) @(posedge clk);
      cmp(onehot, rows[i].onehot);
      cmp(acc, rows[i].acc);
      cmp(mode, rows[i].mode);
      cmp(nref, rows[i].nref);
      cmp(nvld, rows[i].nvld);
    end
    cmp(rd_seen, 36'h9_8765_4321);
    cmp(necho, 1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    cmp(mode, 22'h00_0000);
    cmp(acc, 22'h00_0000);
    cmp(onehot, 8'h00);
    rst_n <= 1'b1;
    host_u.cmd(3'h4, 3'h1, 22'h3f_0000);
    repeat (6) @(posedge clk);
    cmp(mode, 22'h00_0000);
    cmp(onehot, 8'h00);
    host_u.cmd(3'h1, 3'h2, 22'h00_0042);
    host_u.beat(36'hf_ffff_ffff, 1'b1);
    for (int i = 0; i < 18; i++) host_u.beat(36'h1_0000_0000 | 36'(i), 1'b0);
    repeat (6) @(posedge clk);
    cmp(f_rdy, 1'b0);
    wr_rdy <= 1'b1;
    repeat (40) @(posedge clk);
    cmp(nbeat, 16);
    cmp(first[35:0], 36'h1_0000_0000);
    cmp(first[39:37], 3'h2);
    cmp(first[36], 1'b1);
    wrap_up();
  end
endmodule // lldp_port_tb
